// File: rtl/nvm_cell_array.sv
// Purpose: flip-flop cell array with single-location erase and program
// Assumes: one location touched per strobe
// Notes: cells carry no reset, as nonvolatile content survives resets
`timescale 1ns/1ps
module nvm_cell_array #(
	parameter int DW = 8,
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	// clock
	input wire logic core_clk,
	// single location access
	input wire logic [AW-1:0] index,
	input wire logic eraseStb,
	input wire logic progStb,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] cells [DEPTH];

	////////////////////////////////////////////////////////////////////////
	// erase sets all ones, program only pulls bits low; no whole-array path
	always_ff @(posedge core_clk) begin
		if (eraseStb) begin
			cells[index] <= '1;
		end else if (progStb) begin
			cells[index] <= cells[index] & wdata;
		end
	end

	assign rdata = cells[index];

endmodule

// File: rtl/nvm_pkg.sv
// Purpose: shared constants and types of the nonvolatile self-access controller
// Assumes: core clock of 50 MHz
// Notes: write times are plain defaults, shortened for simulation through top parameters
package nvm_pkg;

	// clock and write timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int EE_ERASE_NS = 2000000;
	localparam int EE_PROG_NS = 2000000;
	localparam int PM_ERASE_NS = 2000000;
	localparam int PM_PROG_NS = 2000000;
	// least times, so round up to whole cycles
	localparam int EE_ERASE_CYC = (EE_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EE_PROG_CYC = (EE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PM_ERASE_CYC = (PM_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PM_PROG_CYC = (PM_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	localparam int PM_READ_STEPS = 2;

	// memory geometry
	localparam int EE_DEPTH = 64;
	localparam int EE_AW = 6;
	localparam int EE_DW = 8;
	localparam int PM_DEPTH = 2048;
	localparam int PM_AW = 11;
	localparam int PM_DW = 14;
	localparam int PM_ADDR_W = 13;

	// control register fields
	localparam int CTL_SPACE_BIT = 7;
	localparam int CTL_ABORT_BIT = 3;
	localparam int CTL_EN_BIT = 2;
	localparam int CTL_WR_BIT = 1;
	localparam int CTL_RD_BIT = 0;
	localparam int DONE_FLAG_BIT = 4;
	localparam logic [7:0] REG_RESET = 8'h00;

	// unlock keys, arbitrary values
	localparam logic [7:0] UNLOCK_FIRST = 8'h3C;
	localparam logic [7:0] UNLOCK_SECOND = 8'hC3;

	typedef enum logic [2:0] {
		SEL_DATA_LOW = 3'h0,
		SEL_DATA_HIGH = 3'h1,
		SEL_ADDR_LOW = 3'h2,
		SEL_ADDR_HIGH = 3'h3,
		SEL_CONTROL = 3'h4,
		SEL_UNLOCK = 3'h5,
		SEL_FLAGS = 3'h6
	} sfr_sel_t;

	typedef struct packed {
		logic write;
		sfr_sel_t sel;
		logic [7:0] data;
	} sfr_req_t;

	typedef struct packed {
		logic [7:0] dataLow;
		logic [7:0] dataHigh;
		logic [7:0] addrLow;
		logic [7:0] addrHigh;
		logic [7:0] control;
		logic [7:0] flags;
	} nvm_view_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ERASE = 4'h2,
		ST_PROG = 4'h4,
		ST_PREAD = 4'h8
	} nvm_state_t;

endpackage

// File: rtl/nvm_self_access_ctrl.sv
// Purpose: core-side controller for data EEPROM and program flash self access
// Assumes: sfr writes and instrStep are synchronous one-cycle pulses
// Notes: write times are parameters so simulation can shorten them
`timescale 1ns/1ps
module nvm_self_access_ctrl #(
	parameter int EE_ERASE_CYC = nvm_pkg::EE_ERASE_CYC,
	parameter int EE_PROG_CYC = nvm_pkg::EE_PROG_CYC,
	parameter int PM_ERASE_CYC = nvm_pkg::PM_ERASE_CYC,
	parameter int PM_PROG_CYC = nvm_pkg::PM_PROG_CYC,
	parameter logic [7:0] UNLOCK_FIRST = nvm_pkg::UNLOCK_FIRST,
	parameter logic [7:0] UNLOCK_SECOND = nvm_pkg::UNLOCK_SECOND
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// warm resets
	input wire logic externalReset,
	input wire logic watchdogTimeout,
	// register access from the core
	input wire nvm_pkg::sfr_req_t sfrReq,
	output nvm_pkg::nvm_view_t nvmView,
	// core pipeline
	input wire logic instrStep,
	input wire logic irqEvent,
	output logic coreStall,
	output logic irqVectorReq,
	output logic storeDoneFlag
);

	localparam int CW = nvm_pkg::CNT_W;
	logic [7:0] dataLow_q, addrLow_q, ctlView;
	logic [5:0] dataHigh_q;
	logic [4:0] addrHigh_q;
	logic space_q, abort_q, storeEn_q, storeTrig_q, readTrig_q, doneFlag_q;
	logic rdEe_q, irqQ_q, irqVec_q, resumeWait_q, opPm_q;
	nvm_pkg::nvm_state_t state_q;
	logic [CW-1:0] cnt_q;
	logic [nvm_pkg::PM_AW-1:0] opIdx_q, pmIdx;
	logic [nvm_pkg::PM_DW-1:0] opWord_q, pmRdata;
	logic [1:0] seq_q, step_q;
	logic warmRst, ctlWr, writing, armed, cntZero, startWrite, startRead, progEnd, readDonePm, readFinish;
	logic [nvm_pkg::PM_ADDR_W-1:0] pmAddr;
	logic [nvm_pkg::EE_AW-1:0] eeIdx;
	logic [nvm_pkg::EE_DW-1:0] eeRdata;

	// register select decode, shared by every write path
	function automatic logic hit(input nvm_pkg::sfr_req_t r, input nvm_pkg::sfr_sel_t s);
		return r.write && (r.sel == s);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// start and end conditions
	assign warmRst = externalReset | watchdogTimeout;
	assign ctlWr = hit(sfrReq, nvm_pkg::SEL_CONTROL);
	assign writing = (state_q == nvm_pkg::ST_ERASE) || (state_q == nvm_pkg::ST_PROG);
	assign armed = (seq_q == 2'h2);
	assign cntZero = (cnt_q == '0);
	// enable must already stand before the trigger write
	assign startWrite = ctlWr && sfrReq.data[nvm_pkg::CTL_WR_BIT] && storeEn_q
		&& armed && (state_q == nvm_pkg::ST_IDLE) && !warmRst;
	// a combined trigger write favours the store
	assign startRead = ctlWr && sfrReq.data[nvm_pkg::CTL_RD_BIT] && !startWrite
		&& (state_q == nvm_pkg::ST_IDLE) && !warmRst;
	assign progEnd = (state_q == nvm_pkg::ST_PROG) && cntZero;
	assign readDonePm = (state_q == nvm_pkg::ST_PREAD) && instrStep
		&& (step_q == 2'(nvm_pkg::PM_READ_STEPS - 1));
	assign readFinish = rdEe_q || readDonePm;

	////////////////////////////////////////////////////////////////////////
	// address formation and wrap
	assign pmAddr = {addrHigh_q, addrLow_q};
	assign pmIdx = pmAddr[nvm_pkg::PM_AW-1:0];
	assign eeIdx = addrLow_q[nvm_pkg::EE_AW-1:0];
	// byte-wide data array, one byte per access
	nvm_cell_array #(.DW(nvm_pkg::EE_DW), .DEPTH(nvm_pkg::EE_DEPTH), .AW(nvm_pkg::EE_AW)) eeArray (
		.core_clk(core_clk),
		.index(writing && !opPm_q ? opIdx_q[nvm_pkg::EE_AW-1:0] : eeIdx),
		.eraseStb(!opPm_q && (state_q == nvm_pkg::ST_ERASE) && cntZero && !warmRst),
		.progStb(!opPm_q && progEnd && !warmRst),
		.wdata(opWord_q[nvm_pkg::EE_DW-1:0]),
		.rdata(eeRdata)
	);
	// word-wide program array holding any 14-bit value
	nvm_cell_array #(.DW(nvm_pkg::PM_DW), .DEPTH(nvm_pkg::PM_DEPTH), .AW(nvm_pkg::PM_AW)) pmArray (
		.core_clk(core_clk),
		.index(writing && opPm_q ? opIdx_q : pmIdx),
		.eraseStb(opPm_q && (state_q == nvm_pkg::ST_ERASE) && cntZero && !warmRst),
		.progStb(opPm_q && progEnd && !warmRst),
		.wdata(opWord_q),
		.rdata(pmRdata)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer: erase phase then program phase, or program read wait
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= nvm_pkg::ST_IDLE;
			cnt_q <= '0;
		end else if (warmRst) begin
			state_q <= nvm_pkg::ST_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
				nvm_pkg::ST_IDLE: begin
					if (startWrite) begin
						state_q <= nvm_pkg::ST_ERASE;
						cnt_q <= space_q ? CW'(PM_ERASE_CYC - 1) : CW'(EE_ERASE_CYC - 1);
					end else if (startRead && space_q) begin
						state_q <= nvm_pkg::ST_PREAD;
					end
				end
				nvm_pkg::ST_ERASE: begin
					state_q <= cntZero ? nvm_pkg::ST_PROG : nvm_pkg::ST_ERASE;
					cnt_q <= cntZero ? (opPm_q ? CW'(PM_PROG_CYC - 1) : CW'(EE_PROG_CYC - 1)) : cnt_q - 1'b1;
				end
				nvm_pkg::ST_PROG: begin
					state_q <= cntZero ? nvm_pkg::ST_IDLE : nvm_pkg::ST_PROG;
					cnt_q <= cnt_q - CW'(!cntZero);
				end
				nvm_pkg::ST_PREAD: begin
					if (readDonePm) begin
						state_q <= nvm_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= nvm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// latch target so software may touch the registers during a write
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			opPm_q <= 1'b0;
			opIdx_q <= '0;
			opWord_q <= '0;
		end else if (startWrite) begin
			opPm_q <= space_q;
			opIdx_q <= space_q ? pmIdx : nvm_pkg::PM_AW'(eeIdx);
			opWord_q <= {dataHigh_q, dataLow_q};
		end
	end
	// counts instructions retired while a program read waits
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			step_q <= '0;
		end else begin
			step_q <= (state_q == nvm_pkg::ST_PREAD) ? step_q + 2'(instrStep) : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control bits; warm resets keep space select
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			space_q <= 1'b0;
			abort_q <= 1'b0;
			storeEn_q <= 1'b0;
			storeTrig_q <= 1'b0;
			readTrig_q <= 1'b0;
			rdEe_q <= 1'b0;
		end else if (warmRst) begin
			abort_q <= abort_q | writing;
			storeEn_q <= 1'b0;
			storeTrig_q <= 1'b0;
			readTrig_q <= 1'b0;
			rdEe_q <= 1'b0;
		end else begin
			// space frozen while an access runs, so the target never flips mid-way
			if (ctlWr && (state_q == nvm_pkg::ST_IDLE)) begin
				space_q <= sfrReq.data[nvm_pkg::CTL_SPACE_BIT];
			end
			if (ctlWr) begin
				abort_q <= sfrReq.data[nvm_pkg::CTL_ABORT_BIT];
				storeEn_q <= sfrReq.data[nvm_pkg::CTL_EN_BIT];
			end
			if (startWrite) begin
				storeTrig_q <= 1'b1;
			end else if (progEnd) begin
				storeTrig_q <= 1'b0;
			end
			// software writes of zero are ignored
			if (startRead) begin
				readTrig_q <= 1'b1;
			end else if (readFinish) begin
				readTrig_q <= 1'b0;
			end
			rdEe_q <= startRead && !space_q;
		end
	end
	// unlock register keeps no value, only sequence progress
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seq_q <= 2'h0;
		end else if (warmRst) begin
			seq_q <= 2'h0;
		end else if (hit(sfrReq, nvm_pkg::SEL_UNLOCK)) begin
			if (seq_q == 2'h1 && sfrReq.data == UNLOCK_SECOND) begin
				seq_q <= 2'h2;
			end else begin
				seq_q <= (sfrReq.data == UNLOCK_FIRST) ? 2'h1 : 2'h0;
			end
		end else if (sfrReq.write) begin
			seq_q <= 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data and address registers; untouched by warm resets
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dataLow_q <= nvm_pkg::REG_RESET;
			dataHigh_q <= '0;
		end else if (rdEe_q && !warmRst) begin
			dataLow_q <= eeRdata;
		end else if (readDonePm && !warmRst) begin
			{dataHigh_q, dataLow_q} <= pmRdata;
		end else begin
			if (hit(sfrReq, nvm_pkg::SEL_DATA_LOW)) begin
				dataLow_q <= sfrReq.data;
			end
			if (hit(sfrReq, nvm_pkg::SEL_DATA_HIGH)) begin
				dataHigh_q <= sfrReq.data[5:0];
			end
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			addrLow_q <= nvm_pkg::REG_RESET;
			addrHigh_q <= '0;
		end else begin
			if (hit(sfrReq, nvm_pkg::SEL_ADDR_LOW)) begin
				addrLow_q <= sfrReq.data;
			end
			if (hit(sfrReq, nvm_pkg::SEL_ADDR_HIGH)) begin
				addrHigh_q <= sfrReq.data[4:0];
			end
		end
	end
	// done flag: hardware set beats a same-cycle software clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			doneFlag_q <= 1'b0;
		end else if (warmRst) begin
			doneFlag_q <= 1'b0;
		end else if (progEnd) begin
			doneFlag_q <= 1'b1;
		end else if (hit(sfrReq, nvm_pkg::SEL_FLAGS)) begin
			doneFlag_q <= sfrReq.data[nvm_pkg::DONE_FLAG_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stall and interrupt queue; vector deferred one instruction after resume
	assign coreStall = opPm_q && writing;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irqQ_q <= 1'b0;
			resumeWait_q <= 1'b0;
			irqVec_q <= 1'b0;
		end else if (warmRst) begin
			irqQ_q <= 1'b0;
			resumeWait_q <= 1'b0;
			irqVec_q <= 1'b0;
		end else begin
			if (irqEvent && coreStall) begin
				irqQ_q <= 1'b1;
			end else if (resumeWait_q && instrStep) begin
				irqQ_q <= 1'b0;
			end
			if (progEnd && opPm_q) begin
				resumeWait_q <= 1'b1;
			end else if (instrStep) begin
				resumeWait_q <= 1'b0;
			end
			irqVec_q <= resumeWait_q ? (instrStep && (irqQ_q || irqEvent))
				: (irqEvent && !coreStall);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read views; unlock register reads as zero
	always_comb begin
		ctlView = 8'h00;
		ctlView[nvm_pkg::CTL_SPACE_BIT] = space_q;
		ctlView[nvm_pkg::CTL_ABORT_BIT] = abort_q;
		ctlView[nvm_pkg::CTL_EN_BIT] = storeEn_q;
		ctlView[nvm_pkg::CTL_WR_BIT] = storeTrig_q;
		ctlView[nvm_pkg::CTL_RD_BIT] = readTrig_q;
	end
	assign nvmView = '{dataLow: dataLow_q, dataHigh: {2'b00, dataHigh_q}, addrLow: addrLow_q,
		addrHigh: {3'b000, addrHigh_q}, control: ctlView,
		flags: 8'({7'h00, doneFlag_q} << nvm_pkg::DONE_FLAG_BIT)};
	assign storeDoneFlag = doneFlag_q;
	assign irqVectorReq = irqVec_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	property p_enableGate;
		$rose(storeTrig_q) |-> $past(storeEn_q) && $past(armed);
	endproperty
	a_enableGate: assert property (p_enableGate) else $error("write started without enable or unlock");
	property p_trigEnd;
		progEnd && !warmRst |=> !storeTrig_q && storeDoneFlag;
	endproperty
	a_trigEnd: assert property (p_trigEnd) else $error("write end did not clear trigger or set done");
	property p_pmStall;
		storeTrig_q && opPm_q |-> coreStall;
	endproperty
	a_pmStall: assert property (p_pmStall) else $error("core not stalled in program write");
	property p_eeNoStall;
		storeTrig_q && !opPm_q |-> !coreStall;
	endproperty
	a_eeNoStall: assert property (p_eeNoStall) else $error("core stalled in data write");
	property p_abort;
		writing && warmRst |=> abort_q && !storeTrig_q && state_q == nvm_pkg::ST_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("aborted write not flagged");
	property p_keepRegs;
		warmRst && !sfrReq.write |=> $stable(dataLow_q) && $stable(dataHigh_q) && $stable(addrLow_q)
			&& $stable(addrHigh_q) && $stable(space_q);
	endproperty
	a_keepRegs: assert property (p_keepRegs) else $error("warm reset disturbed held registers");
	property p_eeRead;
		startRead && !space_q ##1 !warmRst |=> nvmView.dataLow == $past(eeRdata) && !readTrig_q;
	endproperty
	a_eeRead: assert property (p_eeRead) else $error("data byte not in next cycle");
	property p_pmRead;
		readDonePm && !warmRst |=> {dataHigh_q, dataLow_q} == $past(pmRdata) && state_q == nvm_pkg::ST_IDLE;
	endproperty
	a_pmRead: assert property (p_pmRead) else $error("program word not loaded");
	property p_rdHold;
		$fell(readTrig_q) |-> $past(readFinish) || $past(warmRst);
	endproperty
	a_rdHold: assert property (p_rdHold) else $error("read trigger cleared early");

endmodule

// File: tb/nvm_core_model.sv
// Purpose: behavioural core that issues register writes and instruction steps
// Assumes: controller samples on the rising edge, so everything moves at the falling edge
// Notes: released data lines carry the inverse of the last value so stale data never looks valid
`timescale 1ns/1ps
module nvm_core_model (
	// clock
	input wire logic core_clk,
	// core side of the controller
	output nvm_pkg::sfr_req_t sfrReq,
	output logic instrStep,
	output logic irqEvent
);
	////////////////////////////////////////////////////////////////////////////
	// quiet start, nothing requested before reset ends
	initial begin
		sfrReq = '0;
		instrStep = 1'b0;
		irqEvent = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// one-cycle register write, data scrambled after release
	task automatic sfr_write(input nvm_pkg::sfr_sel_t sel, input logic [7:0] data);
		@(negedge core_clk);
		sfrReq.write = 1'b1;
		sfrReq.sel = sel;
		sfrReq.data = data;
		@(negedge core_clk);
		sfrReq.write = 1'b0;
		sfrReq.data = ~data;
	endtask

	// one retired instruction, or one interrupt event instead
	task automatic step(input logic irq);
		@(negedge core_clk);
		instrStep = ~irq;
		irqEvent = irq;
		@(negedge core_clk);
		instrStep = 1'b0;
		irqEvent = 1'b0;
	endtask

	// full store: operands, enable, flag clear, unlock pair, trigger
	// the unlock pair must sit right before the trigger, so nothing else goes between
	task automatic store(input logic sp, input logic [12:0] a, input logic [13:0] d);
		sfr_write(nvm_pkg::SEL_ADDR_LOW, a[7:0]);
		sfr_write(nvm_pkg::SEL_ADDR_HIGH, {3'h0, a[12:8]});
		sfr_write(nvm_pkg::SEL_DATA_LOW, d[7:0]);
		sfr_write(nvm_pkg::SEL_DATA_HIGH, {2'h0, d[13:8]});
		sfr_write(nvm_pkg::SEL_CONTROL, {sp, 7'h04});
		sfr_write(nvm_pkg::SEL_FLAGS, 8'h00);
		sfr_write(nvm_pkg::SEL_UNLOCK, nvm_pkg::UNLOCK_FIRST);
		sfr_write(nvm_pkg::SEL_UNLOCK, nvm_pkg::UNLOCK_SECOND);
		sfr_write(nvm_pkg::SEL_CONTROL, {sp, 7'h06});
	endtask
endmodule

// File: tb/nvm_self_access_ctrl_test.sv
// Purpose: self-checking bench for the nonvolatile self-access controller
// Assumes: short erase and program counts so a full store takes a handful of cycles
// Notes: drivers queue expectations, a watcher samples the outputs and compares
`timescale 1ns/1ps
module nvm_self_access_ctrl_test;
	localparam int EEE = 3;
	localparam int EEP = 4;
	localparam int PME = 5;
	localparam int PMP = 6;

	typedef struct {
		int sel;
		logic [15:0] exp;
	} note_t;

	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic externalReset = 1'b0;
	logic watchdogTimeout = 1'b0;
	nvm_pkg::sfr_req_t sfrReq;
	nvm_pkg::nvm_view_t nvmView;
	logic instrStep;
	logic irqEvent;
	logic coreStall;
	logic irqVectorReq;
	logic storeDoneFlag;
	note_t notes[$];
	int error_cnt = 0;
	int n_tests = 0;
	int latCnt = 0;
	logic [12:0] a;
	logic [13:0] d;

	////////////////////////////////////////////////////////////////////////////
	// 50 MHz core clock
	always #10 core_clk = ~core_clk;

	nvm_core_model core_u (
		.core_clk(core_clk),
		.sfrReq(sfrReq),
		.instrStep(instrStep),
		.irqEvent(irqEvent)
	);

	nvm_self_access_ctrl #(
		.EE_ERASE_CYC(EEE),
		.EE_PROG_CYC(EEP),
		.PM_ERASE_CYC(PME),
		.PM_PROG_CYC(PMP)
	) dut_u (
		.core_clk(core_clk),
		.rstn(rstn),
		.externalReset(externalReset),
		.watchdogTimeout(watchdogTimeout),
		.sfrReq(sfrReq),
		.nvmView(nvmView),
		.instrStep(instrStep),
		.irqEvent(irqEvent),
		.coreStall(coreStall),
		.irqVectorReq(irqVectorReq),
		.storeDoneFlag(storeDoneFlag)
	);

	////////////////////////////////////////////////////////////////////////////
	// note an expected value for one output view
	task automatic check_out(input int sel, input logic [15:0] exp);
		note_t nt;
		nt.sel = sel;
		nt.exp = exp;
		notes.push_back(nt);
	endtask

	// count cycles until the done flag shows, bounded
	task automatic wait_done(input int start);
		latCnt = start;
		while (storeDoneFlag !== 1'b1 && latCnt < 200) begin
			@(negedge core_clk);
			latCnt++;
		end
	endtask

	task automatic conclude;
		#1;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watcher: oldest note against the outputs of this time step
	initial begin : watch
		note_t nt;
		logic [15:0] got;
		forever begin
			wait (notes.size() > 0);
			nt = notes.pop_front();
			case (nt.sel)
				0: got = {8'h00, nvmView.dataLow};
				1: got = {nvmView.dataHigh, nvmView.dataLow};
				2: got = {8'h00, nvmView.control};
				3: got = {8'h00, nvmView.flags};
				4: got = {13'h0000, coreStall, irqVectorReq, storeDoneFlag};
				5: got = latCnt[15:0];
				default: got = {nvmView.addrHigh, nvmView.addrLow};
			endcase
			n_tests++;
			if (got !== nt.exp) begin
				error_cnt++;
				$display("MISMATCH %0t view %0d got %h exp %h", $time, nt.sel, got, nt.exp);
			end
		end
	end

	// hang guard, far beyond the longest sequence
	initial begin
		#(20 * 6000);
		error_cnt++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'hCF2EBF79));
		repeat (16) @(negedge core_clk);
		rstn = 1'b1;
		check_out(2, 16'h0000);
		check_out(4, 16'h0000);
		// byte store above the top address, read back at the wrapped address
		a = {7'h01, 6'($urandom())};
		d = 14'($urandom());
		core_u.store(1'b0, a, d);
		wait_done(0);
		check_out(5, 16'(EEE + EEP));
		check_out(3, 16'h0010);
		check_out(2, 16'h0004);
		core_u.sfr_write(nvm_pkg::SEL_ADDR_LOW, {2'h0, a[5:0]});
		core_u.sfr_write(nvm_pkg::SEL_CONTROL, 8'h01);
		check_out(2, 16'h0001);
		@(negedge core_clk);
		check_out(0, {8'h00, d[7:0]});
		check_out(2, 16'h0000);
		// trigger without unlock pair, then without enable
		core_u.sfr_write(nvm_pkg::SEL_CONTROL, 8'h04);
		core_u.sfr_write(nvm_pkg::SEL_CONTROL, 8'h06);
		check_out(2, 16'h0004);
		core_u.sfr_write(nvm_pkg::SEL_CONTROL, 8'h00);
		core_u.sfr_write(nvm_pkg::SEL_FLAGS, 8'h00);
		core_u.sfr_write(nvm_pkg::SEL_UNLOCK, nvm_pkg::UNLOCK_FIRST);
		core_u.sfr_write(nvm_pkg::SEL_UNLOCK, nvm_pkg::UNLOCK_SECOND);
		core_u.sfr_write(nvm_pkg::SEL_CONTROL, 8'h02);
		repeat (EEE + EEP + 2) @(negedge core_clk);
		check_out(2, 16'h0000);
		check_out(3, 16'h0000);
		// word store above 07FFh, interrupt while stalled
		a = {2'h1, 11'($urandom())};
		d = 14'($urandom());
		core_u.store(1'b1, a, d);
		check_out(4, 16'h0004);
		core_u.step(1'b1);
		check_out(4, 16'h0004);
		wait_done(2);
		check_out(5, 16'(PME + PMP));
		check_out(4, 16'h0001);
		core_u.step(1'b0);
		check_out(4, 16'h0003);
		// word read at the wrapped address, old data scrambled first
		core_u.sfr_write(nvm_pkg::SEL_ADDR_HIGH, {5'h00, a[10:8]});
		core_u.sfr_write(nvm_pkg::SEL_DATA_LOW, ~d[7:0]);
		core_u.sfr_write(nvm_pkg::SEL_DATA_HIGH, 8'h00);
		core_u.sfr_write(nvm_pkg::SEL_CONTROL, 8'h81);
		core_u.sfr_write(nvm_pkg::SEL_CONTROL, 8'h80);
		check_out(2, 16'h0081);
		core_u.step(1'b0);
		check_out(1, {8'h00, ~d[7:0]});
		core_u.step(1'b0);
		check_out(1, {2'h0, d});
		check_out(2, 16'h0080);
		// unstalled interrupt goes straight to the vector request
		core_u.step(1'b1);
		check_out(4, 16'h0003);
		// warm reset in mid-store, pin reset on bytes, watchdog on words
		for (int k = 0; k < 2; k++) begin
			a = 13'($urandom());
			d = 14'($urandom());
			core_u.store(k[0], a, d);
			repeat (2) @(negedge core_clk);
			externalReset = ~k[0];
			watchdogTimeout = k[0];
			@(negedge core_clk);
			externalReset = 1'b0;
			watchdogTimeout = 1'b0;
			check_out(2, {8'h00, k[0], 7'h08});
			check_out(1, {2'h0, d});
			check_out(6, {3'h0, a});
			check_out(3, 16'h0000);
			// abort flag cleared by software afterwards
			core_u.sfr_write(nvm_pkg::SEL_CONTROL, {k[0], 7'h00});
			check_out(2, {8'h00, k[0], 7'h00});
		end
		conclude();
	end
endmodule
